// >>> hw/hisl_device.sv
// Interrupt status logic of the adapter: latches the four interrupt sources,
// pauses the sequencer and gates the host interrupt request.
// Assumes sequencer, error and bus-event inputs are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module hisl_device
  import hisl_pkg::*;
#(
  parameter int unsigned PC_W  = 10,
  parameter int unsigned NSECT = 16
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Link to driver-side end
  hisl_if.dev                    lnk,
  // Sequencer
  input  wire logic [PC_W-1:0]   seq_pc,
  input  wire logic [PC_W-1:0]   break_address,
  input  wire logic              seq_status_wr,
  input  wire logic [7:0]        seq_status_wdata,
  input  wire logic              external_block_ram_select,
  input  wire logic              ext_arb_busy,
  output logic                   seq_pause,
  // Failure controls
  input  wire logic              breakpoint_disable,
  input  wire logic              failure_interrupt_disable,
  input  wire logic              parity_error_disable,
  input  wire logic              datapath_parity_check_enable,
  input  wire logic              memory_parity_check_enable,
  // Error sources
  input  wire logic              illegal_instruction_error,
  input  wire logic              sequencer_ram_parity_error,
  input  wire logic              datapath_parity_error,
  input  wire logic              memory_parity_error,
  input  wire logic              host_bus_error,
  // Bus events
  input  wire logic              bus_reset_event,
  input  wire logic              bus_parity_event,
  input  wire logic              select_timeout_event,
  input  wire logic              unexpected_free_event,
  input  wire logic [NSECT-1:0]  section_events,
  input  wire logic [NSECT-1:0]  section_event_mask
);

  logic [BRK_CAUSES-1:0] err_q;
  logic [BRK_CAUSES-1:0] cause_set;
  logic [BRK_CAUSES-1:0] cause_clr;
  logic [BRK_CAUSES-1:0] cause_q;
  logic [BRK_CAUSES-1:0] err_now;
  logic                  breakpoint_interrupt;
  logic                  bus_event_interrupt;
  logic                  command_done_interrupt;
  logic                  sequencer_help_interrupt;
  logic [3:0]            sequencer_reason_code_q;
  logic                  hb_err_q;
  logic                  hb_flag;
  logic                  bus_cause;
  logic                  seq_wr_help;
  logic                  pause_delayable;
  logic                  arb_stall;
  logic                  gate_full;
  logic                  gate_master;
  logic                  clr_parity;

  assign clr_parity = lnk.clear_wr & lnk.clear_bits[CLR_PARITY];

  // Only rising edges of error levels count as new causes
  assign err_now[BRK_ADDR]    = 1'b0;
  assign err_now[BRK_ILLEGAL] = illegal_instruction_error;
  assign err_now[BRK_SEQ_PAR] = sequencer_ram_parity_error;
  assign err_now[BRK_DP_PAR]  = datapath_parity_error;
  assign err_now[BRK_MEM_PAR] = memory_parity_error;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      err_q <= err_now;
    end
  end

  always_comb begin
    cause_set[BRK_ADDR]    = (seq_pc == break_address) & ~breakpoint_disable;
    cause_set[BRK_ILLEGAL] = err_now[BRK_ILLEGAL] & ~err_q[BRK_ILLEGAL]
                             & ~failure_interrupt_disable;
    cause_set[BRK_SEQ_PAR] = err_now[BRK_SEQ_PAR] & ~err_q[BRK_SEQ_PAR]
                             & ~failure_interrupt_disable & ~parity_error_disable;
    cause_set[BRK_DP_PAR]  = err_now[BRK_DP_PAR] & ~err_q[BRK_DP_PAR]
                             & datapath_parity_check_enable
                             & ~failure_interrupt_disable;
    cause_set[BRK_MEM_PAR] = err_now[BRK_MEM_PAR] & ~err_q[BRK_MEM_PAR]
                             & memory_parity_check_enable
                             & ~failure_interrupt_disable;
    cause_clr[BRK_ADDR]    = lnk.clear_wr & lnk.clear_bits[STAT_BREAK];
    cause_clr[BRK_ILLEGAL] = lnk.chip_soft_reset;
    cause_clr[BRK_SEQ_PAR] = clr_parity;
    cause_clr[BRK_DP_PAR]  = clr_parity;
    cause_clr[BRK_MEM_PAR] = clr_parity;
  end

  // One latch per breakpoint cause; the three parity causes share the parity clear
  genvar gi;
  generate
    for (gi = 0; gi < BRK_CAUSES; gi++) begin : g_cause
      hisl_sticky u_cause (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (cause_set[gi]),
        .clr     (cause_clr[gi]),
        .flag_q  (cause_q[gi])
      );
    end
  endgenerate

  assign breakpoint_interrupt = |cause_q;

  // Latched host bus error, cleared alongside parity causes
  assign hb_flag = host_bus_error & ~hb_err_q & ~failure_interrupt_disable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_err_q <= 1'b0;
    end else begin
      hb_err_q <= host_bus_error;
    end
  end

  hisl_sticky u_hberr (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (hb_flag),
    .clr     (clr_parity),
    .flag_q  (lnk.host_bus_error_summary)
  );

  // Level set: a clear while the cause persists is overridden
  assign bus_cause = bus_reset_event | bus_parity_event | select_timeout_event
                     | unexpected_free_event | |(section_events & section_event_mask);

  hisl_sticky u_bus (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (bus_cause),
    .clr     (lnk.clear_wr & lnk.clear_bits[STAT_BUS_EVENT]),
    .flag_q  (bus_event_interrupt)
  );

  // Sequencer writes can only set the help and done flags, never clear them; a help write reloads the code
  assign seq_wr_help = seq_status_wr & seq_status_wdata[STAT_SEQ_HELP];

  hisl_sticky u_cmd (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (seq_status_wr & seq_status_wdata[STAT_CMD_DONE]),
    .clr     (lnk.clear_wr & lnk.clear_bits[STAT_CMD_DONE]),
    .flag_q  (command_done_interrupt)
  );

  hisl_sticky u_help (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (seq_wr_help),
    .clr     (lnk.clear_wr & lnk.clear_bits[STAT_SEQ_HELP]),
    .flag_q  (sequencer_help_interrupt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sequencer_reason_code_q <= 4'h0;
    end else if (seq_wr_help) begin
      sequencer_reason_code_q <= seq_status_wdata[7:STAT_CODE_LSB];
    end
  end

  always_comb begin
    lnk.interrupt_cause_status                 = RST_STATUS;
    lnk.interrupt_cause_status[7:STAT_CODE_LSB] = sequencer_reason_code_q;
    lnk.interrupt_cause_status[STAT_BREAK]     = breakpoint_interrupt;
    lnk.interrupt_cause_status[STAT_BUS_EVENT] = bus_event_interrupt;
    lnk.interrupt_cause_status[STAT_CMD_DONE]  = command_done_interrupt;
    lnk.interrupt_cause_status[STAT_SEQ_HELP]  = sequencer_help_interrupt;
  end

  // Pause; help pauses in the cycle of its own setting write
  assign pause_delayable = breakpoint_interrupt | bus_event_interrupt;
  assign arb_stall       = external_block_ram_select & ext_arb_busy;
  assign seq_pause       = sequencer_help_interrupt | seq_wr_help
                           | (pause_delayable & ~arb_stall);
  assign lnk.pause_active = seq_pause;

  // Command done ignores power-down; the others honour it
  assign gate_master = lnk.interrupt_output_enable & lnk.bus_master_enable;
  assign gate_full   = gate_master & ~lnk.power_down_control;
  assign lnk.host_interrupt_request =
      (gate_full & (breakpoint_interrupt | lnk.host_bus_error_summary))
    | (gate_full & bus_event_interrupt)
    | (gate_full & sequencer_help_interrupt)
    | (gate_master & command_done_interrupt);

endmodule
`default_nettype wire

// >>> common/hisl_pkg.sv
// Package for the host interrupt status logic: field positions, offsets, reset values.
// Assumes one pclk domain shared by both ends.
package hisl_pkg;
  // Cause/status bit positions
  localparam int unsigned STAT_SEQ_HELP  = 0;
  localparam int unsigned STAT_CMD_DONE  = 1;
  localparam int unsigned STAT_BUS_EVENT = 2;
  localparam int unsigned STAT_BREAK     = 3;
  localparam int unsigned STAT_CODE_LSB  = 4;
  localparam int unsigned CLR_PARITY     = 4;
  // Breakpoint cause indices
  localparam int unsigned BRK_ADDR       = 0;
  localparam int unsigned BRK_ILLEGAL    = 1;
  localparam int unsigned BRK_SEQ_PAR    = 2;
  localparam int unsigned BRK_DP_PAR     = 3;
  localparam int unsigned BRK_MEM_PAR    = 4;
  localparam int unsigned BRK_CAUSES     = 5;
  // Host control bit positions
  localparam int unsigned CTL_INT_EN     = 0;
  localparam int unsigned CTL_MASTER_EN  = 1;
  localparam int unsigned CTL_POWER_DOWN = 2;
  localparam int unsigned CTL_CHIP_RST   = 3;
  // APB word offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CLEAR   = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  // Extra status bits in the status word
  localparam int unsigned STW_IRQ    = 8;
  localparam int unsigned STW_PAUSE  = 9;
  localparam int unsigned STW_HBERR  = 10;
  // Reset values
  localparam logic [7:0]  RST_STATUS  = 8'h00;
  localparam logic [2:0]  RST_CONTROL = 3'h0;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
endpackage

// >>> common/hisl_if.sv
// Link between the driver-side register end and the interrupt status logic.
// Assumes both ends run on the same pclk; no clocking block.
`timescale 1ns/1ns
`default_nettype none
interface hisl_if;
  logic       clear_wr;
  logic [7:0] clear_bits;
  logic       interrupt_output_enable;
  logic       bus_master_enable;
  logic       power_down_control;
  logic       chip_soft_reset;
  logic [7:0] interrupt_cause_status;
  logic       host_interrupt_request;
  logic       pause_active;
  logic       host_bus_error_summary;

  modport dev (
    input  clear_wr, clear_bits, interrupt_output_enable, bus_master_enable,
           power_down_control, chip_soft_reset,
    output interrupt_cause_status, host_interrupt_request, pause_active,
           host_bus_error_summary
  );
  modport host (
    output clear_wr, clear_bits, interrupt_output_enable, bus_master_enable,
           power_down_control, chip_soft_reset,
    input  interrupt_cause_status, host_interrupt_request, pause_active,
           host_bus_error_summary
  );
endinterface
`default_nettype wire

// >>> hw/hisl_sticky.sv
// Sticky flag: set wins over a clear in the same cycle.
// Assumes set and clear come from logic on pclk.
`timescale 1ns/1ns
`default_nettype none
module hisl_sticky (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      flag_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hw/hisl_host.sv
// Driver-side end: APB slave holding status, clear and control words.
// Assumes an APB master on pclk; zero-wait slave.
`timescale 1ns/1ns
`default_nettype none
module hisl_host
  import hisl_pkg::*;
#(
  parameter int unsigned AW = 8
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Link to interrupt status logic
  hisl_if.host               lnk
);

  logic       hit_status;
  logic       hit_clear;
  logic       hit_control;
  logic       wr_en;
  logic [2:0] ctl_q;
  logic       clear_wr_q;
  logic [7:0] clear_bits_q;
  logic       chip_rst_q;
  logic [31:0] rdata_q;

  always_comb begin
    hit_status  = 1'b0;
    hit_clear   = 1'b0;
    hit_control = 1'b0;
    if (paddr == AW'(OFS_STATUS)) begin
      hit_status = 1'b1;
    end else if (paddr == AW'(OFS_CLEAR)) begin
      hit_clear = 1'b1;
    end else if (paddr == AW'(OFS_CONTROL)) begin
      hit_control = 1'b1;
    end
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~(hit_status | hit_clear | hit_control);
  assign wr_en   = psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= RST_CONTROL;
    end else if (wr_en & hit_control) begin
      ctl_q <= pwdata[CTL_POWER_DOWN:CTL_INT_EN];
    end
  end

  // Clear and soft-reset words self-clear after one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_wr_q   <= 1'b0;
      clear_bits_q <= 8'h00;
      chip_rst_q   <= 1'b0;
    end else begin
      clear_wr_q   <= wr_en & hit_clear;
      clear_bits_q <= (wr_en & hit_clear) ? pwdata[7:0] : 8'h00;
      chip_rst_q   <= wr_en & hit_control & pwdata[CTL_CHIP_RST];
    end
  end

  // Read data captured in the setup cycle, valid through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= RST_RDATA;
    end else if (psel & ~penable) begin
      rdata_q <= RST_RDATA;
      if (hit_status) begin
        rdata_q[7:0]       <= lnk.interrupt_cause_status;
        rdata_q[STW_IRQ]   <= lnk.host_interrupt_request;
        rdata_q[STW_PAUSE] <= lnk.pause_active;
        rdata_q[STW_HBERR] <= lnk.host_bus_error_summary;
      end else if (hit_control) begin
        rdata_q[CTL_POWER_DOWN:CTL_INT_EN] <= ctl_q;
      end
    end
  end

  assign prdata                      = rdata_q;
  assign lnk.clear_wr                = clear_wr_q;
  assign lnk.clear_bits              = clear_bits_q;
  assign lnk.chip_soft_reset         = chip_rst_q;
  assign lnk.interrupt_output_enable = ctl_q[CTL_INT_EN];
  assign lnk.bus_master_enable       = ctl_q[CTL_MASTER_EN];
  assign lnk.power_down_control      = ctl_q[CTL_POWER_DOWN];

endmodule
`default_nettype wire

// >>> verif/hisl_checker.sv
// Checker on the link between the register end and the status logic.
// Assumes one pclk domain; the bench never sets and clears the help or done flag at once.
`timescale 1ns/1ns
`default_nettype none
module hisl_checker (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Host to device
  input wire logic       clear_wr,
  input wire logic [7:0] clear_bits,
  input wire logic       interrupt_output_enable,
  input wire logic       bus_master_enable,
  input wire logic       power_down_control,
  input wire logic       chip_soft_reset,
  // Device to host
  input wire logic [7:0] interrupt_cause_status,
  input wire logic       host_interrupt_request,
  input wire logic       pause_active,
  input wire logic       host_bus_error_summary
);
  logic en;
  logic enp;
  logic [7:0] st;
  assign en = interrupt_output_enable & bus_master_enable;
  assign enp = en & !power_down_control;
  assign st = interrupt_cause_status;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_clear_self_clr: assert property (clear_wr |=> !clear_wr)
    else $error("clear strobe longer than one cycle");
  a_clear_idle_zero: assert property (!clear_wr |-> clear_bits == 8'h00)
    else $error("clear bits set without strobe");
  a_rst_pulse_one: assert property (chip_soft_reset |=> !chip_soft_reset)
    else $error("soft reset longer than one cycle");
  a_help_clear: assert property (clear_wr && clear_bits[0] |=> !st[0])
    else $error("help flag survived its clear");
  a_cmd_clear: assert property (clear_wr && clear_bits[1] |=> !st[1])
    else $error("command done survived its clear");
  a_help_pause: assert property (st[0] |-> pause_active)
    else $error("help flag without pause");
  a_brk_irq: assert property (st[3] && enp |-> host_interrupt_request)
    else $error("breakpoint request missing");
  a_bus_irq: assert property (st[2] && enp |-> host_interrupt_request)
    else $error("bus event request missing");
  a_cmd_irq: assert property (st[1] && en |-> host_interrupt_request)
    else $error("command done request missing");
  a_help_irq: assert property (st[0] && enp |-> host_interrupt_request)
    else $error("help request missing");
  a_irq_gated: assert property (!en |-> !host_interrupt_request)
    else $error("request while output disabled");
  a_irq_idle: assert property (st[3:0] == 4'h0 && !host_bus_error_summary
    |-> !host_interrupt_request)
    else $error("request with no source");
  a_irq_drop: assert property (clear_wr && clear_bits == 8'h02 && st[3:0] == 4'h2
    && !host_bus_error_summary |=> !host_interrupt_request)
    else $error("request did not drop after last clear");
  c_brk_pause: cover property (st[3] && pause_active);
  c_bus_held: cover property (st[2] && !pause_active);
  c_par_clear: cover property (clear_wr && clear_bits[4]);
endmodule
`default_nettype wire

// >>> verif/test_host_interrupt_status_logic.sv
// Bench: APB master on the register end, direct drive of the status logic.
// Assumes zero-wait APB answers; both ends share pclk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module test_host_interrupt_status_logic;
  import hisl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_pause, seq_status_wr;
  logic [7:0] paddr, seq_status_wdata;
  logic [31:0] pwdata, prdata;
  logic [9:0] seq_pc, break_address;
  logic external_block_ram_select, ext_arb_busy, breakpoint_disable;
  logic failure_interrupt_disable, parity_error_disable;
  logic datapath_parity_check_enable, memory_parity_check_enable;
  logic [4:0] err;
  logic [3:0] bev;
  logic [15:0] section_events, section_event_mask;
  int miscompares, n_checks;
  hisl_if lnk ();
  hisl_host hisl_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lnk(lnk));
  hisl_device hisl_device_inst (.pclk, .presetn, .lnk(lnk), .seq_pc, .break_address,
    .seq_status_wr, .seq_status_wdata, .external_block_ram_select, .ext_arb_busy,
    .seq_pause, .breakpoint_disable, .failure_interrupt_disable, .parity_error_disable,
    .datapath_parity_check_enable, .memory_parity_check_enable,
    .illegal_instruction_error(err[0]), .sequencer_ram_parity_error(err[1]),
    .datapath_parity_error(err[2]), .memory_parity_error(err[3]), .host_bus_error(err[4]),
    .bus_reset_event(bev[0]), .bus_parity_event(bev[1]), .select_timeout_event(bev[2]),
    .unexpected_free_event(bev[3]), .section_events, .section_event_mask);
  hisl_checker hisl_checker_inst (.pclk, .presetn, .clear_wr(lnk.clear_wr),
    .clear_bits(lnk.clear_bits), .interrupt_output_enable(lnk.interrupt_output_enable),
    .bus_master_enable(lnk.bus_master_enable), .power_down_control(lnk.power_down_control),
    .chip_soft_reset(lnk.chip_soft_reset), .interrupt_cause_status(lnk.interrupt_cause_status),
    .host_interrupt_request(lnk.host_interrupt_request), .pause_active(lnk.pause_active),
    .host_bus_error_summary(lnk.host_bus_error_summary));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // No cap of its own: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("pready", 1'b1, pready)
    `CHK("access cycles", 1, n)
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(nm, ex, r & m)
  endtask
  task seq_wr(input logic [7:0] d);
    @(posedge pclk);
    seq_status_wr <= 1'b1;
    seq_status_wdata <= d;
    @(negedge pclk);
    `CHK("pause at write", d[0], seq_pause)
    @(posedge pclk);
    seq_status_wr <= 1'b0;
  endtask
  task pulse(input int i);
    @(posedge pclk);
    err[i] <= 1'b1;
    @(posedge pclk);
    err[i] <= 1'b0;
  endtask
  // Off selects which error stays masked; 9 leaves all checking on
  task gates(input int off);
    @(posedge pclk);
    failure_interrupt_disable <= (off == 0);
    parity_error_disable <= (off == 1);
    datapath_parity_check_enable <= (off != 2);
    memory_parity_check_enable <= (off != 3);
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    rd("status rst", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_000F);
    rd("control", OFS_CONTROL, 32'hFFFF_FFFF, 32'h0000_0007);
    rd("clear rd", OFS_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_00FF);
    rd("status ro", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, r)
  endtask
  task t_help_cmd;
    wr(OFS_CONTROL, 32'h0000_0003);
    seq_wr(8'hA1);
    rd("help", OFS_STATUS, 32'h0000_07FF, 32'h0000_03A1);
    wr(OFS_CONTROL, 32'h0000_0007);
    rd("help pd", OFS_STATUS, 32'h0000_0100, 32'h0000_0000);
    wr(OFS_CLEAR, 32'h0000_0001);
    rd("help clr", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
    seq_wr(8'h52);
    rd("cmd", OFS_STATUS, 32'h0000_030F, 32'h0000_0102);
    wr(OFS_CONTROL, 32'h0000_0001);
    rd("cmd no master", OFS_STATUS, 32'h0000_0100, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0003);
    wr(OFS_CLEAR, 32'h0000_0002);
    rd("cmd clr", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
  endtask
  task t_brk;
    wr(OFS_CONTROL, 32'h0000_0003);
    @(posedge pclk);
    breakpoint_disable <= 1'b1;
    seq_pc <= break_address;
    rd("brk off", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
    breakpoint_disable <= 1'b0;
    @(posedge pclk);
    seq_pc <= 10'h000;
    rd("brk", OFS_STATUS, 32'h0000_070F, 32'h0000_0308);
    wr(OFS_CLEAR, 32'h0000_0008);
    rd("brk clr", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
  endtask
  task t_err;
    for (int i = 0; i < 4; i++) begin
      gates(i);
      pulse(i);
      rd("err masked", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
      gates(9);
      pulse(i);
      rd("err set", OFS_STATUS, 32'h0000_030F, 32'h0000_0308);
      if (i == 0) wr(OFS_CLEAR, 32'h0000_0008);
      else wr(OFS_CONTROL, 32'h0000_000B);
      rd("err held", OFS_STATUS, 32'h0000_030F, 32'h0000_0308);
      if (i == 0) wr(OFS_CONTROL, 32'h0000_000B);
      else wr(OFS_CLEAR, 32'h0000_0010);
      rd("err clr", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
    end
    pulse(4);
    rd("hb err", OFS_STATUS, 32'h0000_070F, 32'h0000_0500);
    wr(OFS_CLEAR, 32'h0000_0010);
    rd("hb clr", OFS_STATUS, 32'h0000_070F, 32'h0000_0000);
  endtask
  task t_bus;
    @(posedge pclk);
    external_block_ram_select <= 1'b1;
    ext_arb_busy <= 1'b1;
    section_event_mask <= 16'h0020;
    section_events <= 16'h0040;
    rd("unmasked", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
    section_events <= 16'h0000;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      if (i < 4) bev[i] <= 1'b1;
      else section_events <= 16'h0020;
      repeat (2) @(negedge pclk);
      `CHK("pause held", 1'b0, seq_pause)
      @(posedge pclk);
      ext_arb_busy <= 1'b0;
      @(negedge pclk);
      `CHK("pause", 1'b1, seq_pause)
      rd("bus", OFS_STATUS, 32'h0000_070F, 32'h0000_0304);
      wr(OFS_CLEAR, 32'h0000_0004);
      rd("bus held", OFS_STATUS, 32'h0000_030F, 32'h0000_0304);
      bev <= 4'h0;
      section_events <= 16'h0000;
      wr(OFS_CLEAR, 32'h0000_0004);
      rd("bus clr", OFS_STATUS, 32'h0000_030F, 32'h0000_0000);
      ext_arb_busy <= 1'b1;
    end
  endtask
  initial begin
    #800000;
    miscompares++;
    complete_run;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, seq_status_wr, external_block_ram_select, ext_arb_busy} = 6'h00;
    {breakpoint_disable, failure_interrupt_disable, parity_error_disable} = 3'h0;
    {datapath_parity_check_enable, memory_parity_check_enable} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seq_status_wdata = 8'h00;
    seq_pc = 10'h000;
    break_address = 10'h155;
    err = 5'h00;
    bev = 4'h0;
    section_events = 16'h0000;
    section_event_mask = 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_help_cmd;
    t_brk;
    t_err;
    t_bus;
    complete_run;
  end
endmodule
`default_nettype wire
